// >>> logic/pg_seq_pkg.sv
// power-good sequencing package: register map, reset values, delay tables, carriers
// assumes a single 25 MHz core clock and a free-running slow tick derived from it
`default_nettype none
package pg_seq_pkg;
   // core clock and slow tick
   localparam int          CLOCK_PERIOD_NS = 40;
   localparam int          TICK_PERIOD_NS  = 30500;
   localparam int          TICK_CYCLES     = (TICK_PERIOD_NS + CLOCK_PERIOD_NS - 1)
                                             / CLOCK_PERIOD_NS;
   localparam int          TICK_CNT_W      = $clog2(TICK_CYCLES);
   localparam int          DELAY_CNT_W     = 12;    // holds the longest delay, 3280 ticks
   localparam int          RAIL_COUNT      = 8;

   // register offsets
   localparam logic [7:0]  ADDR_PG_DELAY   = 8'h40;
   localparam logic [7:0]  ADDR_CTRL_EN    = 8'h41;
   localparam logic [7:0]  ADDR_WR_LOCK    = 8'h42;
   localparam logic [7:0]  ADDR_PIN_MASK   = 8'h43;

   // reset values
   localparam logic [6:0]  RST_PG_DELAY    = 7'h5f;  // bit 7 is reserved and not stored
   localparam logic [7:0]  RST_CTRL_EN     = 8'h00;
   localparam logic        RST_WR_LOCK     = 1'b0;
   localparam logic [7:0]  RST_PIN_MASK    = 8'h00;

   // field positions in the power-good delay, controller enable and write lock registers
   localparam int          RESUME_SEL_LSB  = 5;
   localparam int          HUB_SEL_LSB     = 3;
   localparam int          SYS_SEL_LSB     = 0;
   localparam int          CTRL_S4_BIT     = 1;
   localparam int          CTRL_DS4_BIT    = 0;
   localparam int          WR_LOCK_BIT     = 0;

   // register access request from the serial interface front end
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_t;

   // delayed power-good outputs
   typedef struct packed {
      logic resume_reset_powergood;
      logic platform_hub_power_ok;
      logic system_power_ok;
   } pg_out_t;

   // delay tables in slow-tick periods; zero means no delay
   function automatic logic [DELAY_CNT_W-1:0] resume_delay(input logic [1:0] sel);
      case (sel)
         2'h0:    resume_delay = 12'd0;
         2'h1:    resume_delay = 12'd164;
         2'h2:    resume_delay = 12'd360;
         default: resume_delay = 12'd721;
      endcase
   endfunction : resume_delay

   function automatic logic [DELAY_CNT_W-1:0] hub_delay(input logic [1:0] sel);
      case (sel)
         2'h0:    hub_delay = 12'd82;
         2'h1:    hub_delay = 12'd164;
         2'h2:    hub_delay = 12'd328;
         default: hub_delay = 12'd656;
      endcase
   endfunction : hub_delay

   function automatic logic [DELAY_CNT_W-1:0] sys_delay(input logic [2:0] sel);
      case (sel)
         3'h0:    sys_delay = 12'd82;
         3'h1:    sys_delay = 12'd164;
         3'h2:    sys_delay = 12'd328;
         3'h3:    sys_delay = 12'd492;
         3'h4:    sys_delay = 12'd656;
         3'h5:    sys_delay = 12'd1640;
         3'h6:    sys_delay = 12'd2460;
         default: sys_delay = 12'd3280;
      endcase
   endfunction : sys_delay
endpackage : pg_seq_pkg
`default_nettype wire

// >>> logic/powergood_delay_and_rail_enable_ctrl.sv
// power-good delay timing and regulator enable selection
// assumes register requests arrive on the core clock from a serial front end, and that
// power-good and enable pins are asynchronous and are synchronised here
`default_nettype none

// Overview of operation
// - resume power-good delayed by 2-bit select
// - hub power-ok follows all-rails good, 2-bit delay
// - system power-ok follows all-rails good, 3-bit delay
// - delay register resets 0x5f, bit 7 zero
// - lock bit blocks rail control register writes
// - mask bit zero: enable pin drives regulator
// - mask bit one: software enable drives regulator
// - mask bits map rails 7..0, reset zero
module powergood_delay_and_rail_enable_ctrl
   import pg_seq_pkg::*;
#(
   parameter int RAILS = RAIL_COUNT
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // register access
   input  wire reg_req_t         reg_req,
   output logic [7:0]            reg_rdata,
   output logic                  reg_rvalid,
   // power-good references (pins)
   input  wire logic             resume_rails_powergood,
   input  wire logic             all_rails_powergood,
   // delayed power-good outputs
   output pg_out_t               pg_out,
   // rail enables: pins, software fields, results
   input  wire logic [RAILS-1:0] rail_enable_pin,
   input  wire logic [RAILS-1:0] rail_software_enable,
   output logic [RAILS-1:0]      rail_enable,
   // rail control register write gating
   input  wire logic             rail_ctl_wr,
   output logic                  rail_ctl_wr_allowed,
   output logic                  control_write_lock,
   // stored controller enables
   output logic                  controller_sleep_s4_enable,
   output logic                  controller_deep_s4_enable
);

   // register state
   logic [6:0]            powergood_delay_cfg_reg;
   logic [7:0]            controller_state_enable_reg;
   logic                  control_write_lock_reg;
   logic [7:0]            rail_enable_pin_mask_reg;

   // synchronisers
   logic [1:0]            ref_meta_reg;
   logic [1:0]            ref_sync_reg;
   logic [RAILS-1:0]      pin_meta_reg;
   logic [RAILS-1:0]      pin_sync_reg;

   // slow tick
   logic [TICK_CNT_W-1:0] tick_cnt_reg;
   logic                  tick;

   // delay channels: 0 resume, 1 hub, 2 system
   logic [2:0]                  chan_ref;
   logic [DELAY_CNT_W-1:0]      chan_target [3];
   logic [DELAY_CNT_W-1:0]      chan_cnt_reg [3];
   logic [2:0]                  chan_out_reg;

   // register writes; reserved bit 7 of the delay register is not stored
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         powergood_delay_cfg_reg     <= RST_PG_DELAY;
         controller_state_enable_reg <= RST_CTRL_EN;
         control_write_lock_reg      <= RST_WR_LOCK;
         rail_enable_pin_mask_reg    <= RST_PIN_MASK;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            ADDR_PG_DELAY: begin
               powergood_delay_cfg_reg <= reg_req.wdata[6:0];
            end
            ADDR_CTRL_EN: begin
               controller_state_enable_reg <= reg_req.wdata;
            end
            ADDR_WR_LOCK: begin
               control_write_lock_reg <= reg_req.wdata[WR_LOCK_BIT];
            end
            ADDR_PIN_MASK: begin
               rail_enable_pin_mask_reg <= reg_req.wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // register reads answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd) begin
            case (reg_req.addr)
               ADDR_PG_DELAY: begin
                  reg_rdata <= {1'b0, powergood_delay_cfg_reg};
               end
               ADDR_CTRL_EN: begin
                  reg_rdata <= controller_state_enable_reg;
               end
               ADDR_WR_LOCK: begin
                  reg_rdata <= {7'h00, control_write_lock_reg};
               end
               ADDR_PIN_MASK: begin
                  reg_rdata <= rail_enable_pin_mask_reg;
               end
               default: begin
                  reg_rdata <= 8'h00;
               end
            endcase
         end
      end
   end

   // lock gates writes to the rail control registers held elsewhere
   assign control_write_lock  = control_write_lock_reg;
   assign rail_ctl_wr_allowed = rail_ctl_wr & ~control_write_lock_reg;

   // stored controller enables
   assign controller_sleep_s4_enable = controller_state_enable_reg[CTRL_S4_BIT];
   assign controller_deep_s4_enable  = controller_state_enable_reg[CTRL_DS4_BIT];

   // two-stage synchronisers for the power-good reference pins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ref_meta_reg <= 2'h0;
         ref_sync_reg <= 2'h0;
      end else begin
         ref_meta_reg <= {all_rails_powergood, resume_rails_powergood};
         ref_sync_reg <= ref_meta_reg;
      end
   end

   // two-stage synchronisers for the regulator enable pins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= rail_enable_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // free-running slow tick prescaler, one pulse every TICK_CYCLES clocks
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end
   assign tick = (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1));

   // reference and target per channel
   assign chan_ref       = {ref_sync_reg[1], ref_sync_reg[1], ref_sync_reg[0]};
   assign chan_target[0] = resume_delay(
                              powergood_delay_cfg_reg[RESUME_SEL_LSB +: 2]);
   assign chan_target[1] = hub_delay(
                              powergood_delay_cfg_reg[HUB_SEL_LSB +: 2]);
   assign chan_target[2] = sys_delay(
                              powergood_delay_cfg_reg[SYS_SEL_LSB +: 3]);

   // delay counters: cleared while the reference is low, count ticks after it rises,
   // and the output rises once the count reaches the selected target
   for (genvar c = 0; c < 3; c++) begin : g_delay
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            chan_cnt_reg[c] <= '0;
            chan_out_reg[c] <= 1'b0;
         end else if (!chan_ref[c]) begin
            chan_cnt_reg[c] <= '0;
            chan_out_reg[c] <= 1'b0;
         end else begin
            if (tick && chan_cnt_reg[c] < chan_target[c]) begin
               chan_cnt_reg[c] <= chan_cnt_reg[c] + 1'b1;
            end
            chan_out_reg[c] <= (chan_cnt_reg[c] >= chan_target[c]);
         end
      end
   end

   assign pg_out.resume_reset_powergood = chan_out_reg[0];
   assign pg_out.platform_hub_power_ok  = chan_out_reg[1];
   assign pg_out.system_power_ok        = chan_out_reg[2];

   // regulator enable per rail: pin when unmasked, software field when masked
   for (genvar r = 0; r < RAILS; r++) begin : g_rail
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            rail_enable[r] <= 1'b0;
         end else if (rail_enable_pin_mask_reg[r]) begin
            rail_enable[r] <= rail_software_enable[r];
         end else begin
            rail_enable[r] <= pin_sync_reg[r];
         end
      end
   end

endmodule : powergood_delay_and_rail_enable_ctrl
`default_nettype wire

// >>> sim/pg_ctrl_asserts.sv
// checker for the power-good delay block: register answers, lock gating, delay timing
// assumes only the top-level ports; bound to every instance of the block
`default_nettype none
module pg_ctrl_checker
   import pg_seq_pkg::*;
#(parameter int RAILS = RAIL_COUNT) (
   input wire logic     clock,
   input wire logic     nrst,
   input wire reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic     reg_rvalid,
   input wire logic     resume_rails_powergood,
   input wire logic     all_rails_powergood,
   input wire pg_out_t  pg_out,
   input wire logic     rail_ctl_wr,
   input wire logic     rail_ctl_wr_allowed,
   input wire logic     control_write_lock,
   input wire logic     controller_sleep_s4_enable,
   input wire logic     controller_deep_s4_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   localparam int MIN_WAIT = 81 * TICK_CYCLES;
   logic [16:0] hi_cnt;
   // cycles the all-rails reference has stood high, saturating
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) hi_cnt <= '0;
      else if (!all_rails_powergood) hi_cnt <= '0;
      else if (!(&hi_cnt)) hi_cnt <= hi_cnt + 17'd1;
   end
   sequence all_low_s; !all_rails_powergood [*4]; endsequence
   sequence res_low_s; !resume_rails_powergood [*4]; endsequence
   chk_rd_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
   chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd)) else $error("stray rvalid");
   chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("rdata moved");
   chk_lock_gate: assert property (rail_ctl_wr_allowed == (rail_ctl_wr && !control_write_lock))
      else $error("lock gate wrong");
   chk_lock_write: assert property (reg_req.wr && reg_req.addr == ADDR_WR_LOCK
      |=> control_write_lock == $past(reg_req.wdata[0])) else $error("lock not stored");
   chk_ctrl_en_write: assert property (reg_req.wr && reg_req.addr == ADDR_CTRL_EN
      |=> {controller_sleep_s4_enable, controller_deep_s4_enable} == $past(reg_req.wdata[1:0]))
      else $error("controller enables not stored");
   chk_hub_early: assert property ($rose(pg_out.platform_hub_power_ok) |-> hi_cnt >= MIN_WAIT)
      else $error("hub ok early");
   chk_sys_early: assert property ($rose(pg_out.system_power_ok) |-> hi_cnt >= MIN_WAIT)
      else $error("system ok early");
   chk_ref_fall: assert property (all_low_s |-> !pg_out.platform_hub_power_ok
      && !pg_out.system_power_ok) else $error("ok outputs held after fall");
   chk_res_fall: assert property (res_low_s |-> !pg_out.resume_reset_powergood)
      else $error("resume output held after fall");
endmodule : pg_ctrl_checker
bind powergood_delay_and_rail_enable_ctrl pg_ctrl_checker #(.RAILS(RAILS)) chk_u (
   .clock(clock), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .resume_rails_powergood(resume_rails_powergood),
   .all_rails_powergood(all_rails_powergood), .pg_out(pg_out), .rail_ctl_wr(rail_ctl_wr),
   .rail_ctl_wr_allowed(rail_ctl_wr_allowed), .control_write_lock(control_write_lock),
   .controller_sleep_s4_enable(controller_sleep_s4_enable),
   .controller_deep_s4_enable(controller_deep_s4_enable));
`default_nettype wire

// >>> sim/far_side_pins.sv
// far-side model: hub and controller pins feeding the block
// assumes bench commands on the core clock; slow adds one cycle of latency
`default_nettype none
module far_side_pins (
   input wire logic       clock,
   input wire logic       slow,
   input wire logic [1:0] pg_set,
   input wire logic [7:0] pin_set,
   output logic           resume_good,
   output logic           all_good,
   output logic [7:0]     en_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] stage_q;
   // one stage for a prompt answer, two for a slow one
   always_ff @(posedge clock) begin
      stage_q <= {pg_set, pin_set};
      {resume_good, all_good, en_pins} <= slow ? stage_q : {pg_set, pin_set};
   end
endmodule : far_side_pins
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench: register access, lock, pin masking and power-good delays
// assumes the far-side pin model and the bound checker
`default_nettype none
module tb_top;
   import pg_seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, nrst, res_pin, all_pin, ctl_wr, allowed, lock, s4, ds4, rvalid, slow;
   logic [7:0] rdata, pins, sw, ren, pin_set;
   logic [1:0] pg_set;
   reg_req_t req;
   pg_out_t pg;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   powergood_delay_and_rail_enable_ctrl dut_u (.clock(clock), .nrst(nrst), .reg_req(req),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .resume_rails_powergood(res_pin),
      .all_rails_powergood(all_pin), .pg_out(pg), .rail_enable_pin(pins),
      .rail_software_enable(sw), .rail_enable(ren), .rail_ctl_wr(ctl_wr),
      .rail_ctl_wr_allowed(allowed), .control_write_lock(lock),
      .controller_sleep_s4_enable(s4), .controller_deep_s4_enable(ds4));
   far_side_pins far_u (.clock(clock), .slow(slow), .pg_set(pg_set), .pin_set(pin_set),
      .resume_good(res_pin), .all_good(all_pin), .en_pins(pins));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clock);
      req <= '0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clock);
      req <= '0;
      @(negedge clock);
      check({7'h00, rvalid}, 8'h01);
      check(rdata, exp);
   endtask : reg_read
   task automatic final_report;
      if (err_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // cut a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      {nrst, req, sw, slow, pg_set, pin_set} = '0;
      ctl_wr = 1'b1;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      // reset values, reserved bits, unmapped place
      reg_read(ADDR_PG_DELAY, 8'h5f);
      reg_read(ADDR_CTRL_EN, 8'h00);
      reg_read(ADDR_WR_LOCK, 8'h00);
      reg_read(ADDR_PIN_MASK, 8'h00);
      reg_read(8'h44, 8'h00);
      reg_write(ADDR_PG_DELAY, 8'hff);
      reg_read(ADDR_PG_DELAY, 8'h7f);
      reg_write(ADDR_CTRL_EN, 8'hfe);
      reg_read(ADDR_CTRL_EN, 8'hfe);
      check({6'h00, s4, ds4}, 8'h02);
      // lock gates the rail control strobe
      reg_write(ADDR_WR_LOCK, 8'hff);
      reg_read(ADDR_WR_LOCK, 8'h01);
      check({7'h00, allowed}, 8'h00);
      reg_write(ADDR_WR_LOCK, 8'h00);
      reg_read(ADDR_WR_LOCK, 8'h00);
      check({7'h00, allowed}, 8'h01);
      // pins with a prompt far side, then mask with a slow one; inputs change on the rising edge
      @(posedge clock);
      pin_set <= 8'ha5;
      sw <= 8'h3c;
      repeat (6) @(negedge clock);
      check(ren, 8'ha5);
      reg_write(ADDR_PIN_MASK, 8'hf0);
      slow <= 1'b1;
      pin_set <= 8'h5a;
      repeat (8) @(negedge clock);
      check(ren, 8'h3a);
      // shortest delays, rise, fall and restart
      reg_write(ADDR_PG_DELAY, 8'h00);
      pg_set <= 2'b11;
      repeat (7) @(negedge clock);
      check({5'h00, pg}, 8'h04);
      repeat (80 * TICK_CYCLES) @(negedge clock);
      check({5'h00, pg}, 8'h04);
      for (int i = 0; i < 3 * TICK_CYCLES && pg !== 3'b111; i++) @(negedge clock);
      check({5'h00, pg}, 8'h07);
      @(posedge clock);
      pg_set <= 2'b10;
      repeat (6) @(negedge clock);
      check({5'h00, pg}, 8'h04);
      @(posedge clock);
      pg_set <= 2'b01;
      repeat (8) @(negedge clock);
      check({5'h00, pg}, 8'h00);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
